// file: shared/oms_pkg.sv
// Package for the operation mode selector: register map, codes, defaults
package oms_pkg;

  // Register byte addresses
  localparam logic [7:0] OMS_REG_MODE_SEL    = 8'h00;
  localparam logic [7:0] OMS_REG_ACCEL       = 8'h04;
  localparam logic [7:0] OMS_REG_DECEL       = 8'h08;
  localparam logic [7:0] OMS_REG_RAMP2       = 8'h0C;
  localparam logic [7:0] OMS_REG_DECEL2      = 8'h10;
  localparam logic [7:0] OMS_REG_CAL_BASE    = 8'h14;
  localparam logic [7:0] OMS_REG_STATUS      = 8'h2C;
  localparam logic [7:0] OMS_REG_CLEAR       = 8'h30;
  localparam logic [7:0] OMS_REG_EFF_DECEL   = 8'h34;

  // Calibration parameter count (900..905)
  localparam int unsigned OMS_CAL_NUM        = 6;

  // Mode selection values
  localparam logic [2:0] OMS_SEL_SWITCH      = 3'h0;
  localparam logic [2:0] OMS_SEL_PANEL_ONLY  = 3'h1;
  localparam logic [2:0] OMS_SEL_TERM_ONLY   = 3'h2;
  localparam logic [2:0] OMS_SEL_COMB_FREQ   = 3'h3;
  localparam logic [2:0] OMS_SEL_COMB_RUN    = 3'h4;

  // Time values in 0.1 s units
  localparam logic [15:0] OMS_TIME_SMALL     = 16'h0032;
  localparam logic [15:0] OMS_TIME_LARGE     = 16'h0096;
  localparam logic [15:0] OMS_TIME_RAMP2     = 16'h0032;
  localparam logic [15:0] OMS_SAME_AS_RAMP2  = 16'h270F;
  localparam logic [15:0] OMS_CAL_RESET      = 16'h0000;

  // Clear register bits
  localparam int unsigned OMS_CLR_PARAM_BIT  = 0;
  localparam int unsigned OMS_CLR_ALL_BIT    = 1;

  // Status register fields
  localparam int unsigned OMS_ST_MODE_LSB    = 0;
  localparam int unsigned OMS_ST_RUN_SRC_BIT = 2;
  localparam int unsigned OMS_ST_FRQ_SRC_BIT = 3;
  localparam int unsigned OMS_ST_FSCR_BIT    = 4;

  typedef enum logic [1:0] {
    OMS_MODE_TERMINAL = 2'b00,
    OMS_MODE_PANEL    = 2'b01,
    OMS_MODE_COMBINED = 2'b10
  } oms_mode_t;

endpackage

// file: verilog/oms_selector.sv
// Operation mode selector: mode state, command sources, parameter store
//
// Notes on behaviour
// RULE1: After reset the selector is in terminal mode with terminal sources.
// RULE2: Panel mode key with both start inputs off enters panel mode and the entry screen.
// RULE3: Terminal mode key leaves panel mode only with starts off and no run, then shows label.
// RULE4: Any panel key mode change is ignored while either start input is on.
// RULE5: Writing mode selection 3 or 4 enters combined mode and shows the combined label.
// RULE6: Selection 3 takes frequency from the panel and run from the start inputs.
// RULE7: Selection 4 takes frequency from the terminals and run from panel keys.
// RULE8: Selection 0 starts in terminal mode and lets the keys switch modes.
// RULE9: Selection 1 holds panel mode and refuses any switch.
// RULE10: Selection 2 holds terminal mode and refuses any switch.
// RULE11: Second decel time of 9999 makes decel use the second ramp time.
// RULE12: Ramp defaults are 5 s or 15 s by rating, second ramp 5 s.
// RULE13: Parameter clear restores all but the six calibration parameters.
// RULE14: All-parameter clear restores every parameter including calibration.
// RULE15: A refused switch leaves mode, sources and indication unchanged.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module oms_selector #(
  parameter bit LARGE_RATING = 1'b0
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  // Register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  // Terminal pins, asynchronous
  input  wire logic                 forward_start_input,
  input  wire logic                 reverse_start_input,
  // Panel keys, synchronous one-cycle pulses
  input  wire logic                 panel_mode_key,
  input  wire logic                 terminal_mode_key,
  input  wire logic                 panel_fwd_key,
  input  wire logic                 panel_rev_key,
  input  wire logic                 panel_stop_key,
  // Mode indication and sources
  output oms_pkg::oms_mode_t        mode,
  output logic                      terminal_mode_label,
  output logic                      combined_mode_label,
  output logic                      freq_entry_screen,
  output logic                      run_from_panel,
  output logic                      freq_from_panel,
  output logic                      run_active,
  output logic                      run_reverse,
  // Effective ramp times
  output logic [15:0]               accel_time_out,
  output logic [15:0]               decel_time_out
);
  import oms_pkg::*;

  // Ramp default depends on the rating
  localparam logic [15:0] RAMP_DFLT = LARGE_RATING ? OMS_TIME_LARGE : OMS_TIME_SMALL;

  ////////////////////////////////////////////////////////////////////////////
  // Start input synchronisers
  logic [2:0] fwd_sync_q;
  logic [2:0] rev_sync_q;
  logic       fwd_q;
  logic       rev_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fwd_sync_q <= 3'h0;
      rev_sync_q <= 3'h0;
    end else begin
      fwd_sync_q <= {fwd_sync_q[1:0], forward_start_input};
      rev_sync_q <= {rev_sync_q[1:0], reverse_start_input};
    end
  end

  // Change accepted once stages two and three agree
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fwd_q <= 1'b0;
      rev_q <= 1'b0;
    end else begin
      if (fwd_sync_q[1] == fwd_sync_q[2]) begin
        fwd_q <= fwd_sync_q[2];
      end
      if (rev_sync_q[1] == rev_sync_q[2]) begin
        rev_q <= rev_sync_q[2];
      end
    end
  end

  logic starts_off;
  assign starts_off = !fwd_q && !rev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter store
  logic [2:0]  mode_sel_q;
  logic [15:0] accel_q;
  logic [15:0] decel_q;
  logic [15:0] ramp2_q;
  logic [15:0] decel2_q;
  logic [15:0] cal_q [OMS_CAL_NUM];
  logic        mode_sel_wr;
  logic        clr_param;
  logic        clr_all;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
    hit = (a == base);
  endfunction

  assign mode_sel_wr = reg_wr && hit(reg_addr, OMS_REG_MODE_SEL) && reg_wdata[2:0] <= 3'h4;
  assign clr_param   = reg_wr && hit(reg_addr, OMS_REG_CLEAR) && reg_wdata[OMS_CLR_PARAM_BIT];
  assign clr_all     = reg_wr && hit(reg_addr, OMS_REG_CLEAR) && reg_wdata[OMS_CLR_ALL_BIT];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode_sel_q <= OMS_SEL_SWITCH;
      accel_q    <= RAMP_DFLT;
      decel_q    <= RAMP_DFLT;
      ramp2_q    <= OMS_TIME_RAMP2;
      decel2_q   <= OMS_SAME_AS_RAMP2;
    // RULE13 RULE14 clear common part
    end else if (clr_param || clr_all) begin
      // RULE12 factory ramp values
      mode_sel_q <= OMS_SEL_SWITCH;
      accel_q    <= RAMP_DFLT;
      decel_q    <= RAMP_DFLT;
      ramp2_q    <= OMS_TIME_RAMP2;
      decel2_q   <= OMS_SAME_AS_RAMP2;
    end else if (reg_wr) begin
      // Out of range mode values are ignored
      if (mode_sel_wr) begin
        mode_sel_q <= reg_wdata[2:0];
      end
      if (hit(reg_addr, OMS_REG_ACCEL)) begin
        accel_q <= reg_wdata[15:0];
      end
      if (hit(reg_addr, OMS_REG_DECEL)) begin
        decel_q <= reg_wdata[15:0];
      end
      if (hit(reg_addr, OMS_REG_RAMP2)) begin
        ramp2_q <= reg_wdata[15:0];
      end
      if (hit(reg_addr, OMS_REG_DECEL2)) begin
        decel2_q <= reg_wdata[15:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < OMS_CAL_NUM; gi++) begin : g_cal
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          cal_q[gi] <= OMS_CAL_RESET;
        // RULE14 calibration cleared only here
        end else if (clr_all) begin
          cal_q[gi] <= OMS_CAL_RESET;
        // RULE13 kept on plain clear
        end else if (reg_wr && !clr_param &&
                     hit(reg_addr, OMS_REG_CAL_BASE + 8'(4 * gi))) begin
          cal_q[gi] <= reg_wdata[15:0];
        end
      end
    end
  endgenerate

  // RULE11 decel falls back to second ramp
  logic [15:0] eff_decel2;
  assign eff_decel2 = (decel2_q == OMS_SAME_AS_RAMP2) ? ramp2_q : decel2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Operation mode
  logic [2:0] new_sel;
  assign new_sel = reg_wdata[2:0];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      // RULE1 terminal mode after power on
      mode              <= OMS_MODE_TERMINAL;
      freq_entry_screen <= 1'b0;
    end else if (clr_param || clr_all) begin
      // RULE8 default selection restarts in terminal
      mode              <= OMS_MODE_TERMINAL;
      freq_entry_screen <= 1'b0;
    end else if (mode_sel_wr) begin
      case (new_sel)
        // RULE9 panel only
        OMS_SEL_PANEL_ONLY: begin
          mode              <= OMS_MODE_PANEL;
          freq_entry_screen <= 1'b1;
        end
        // RULE10 terminal only
        OMS_SEL_TERM_ONLY: begin
          mode              <= OMS_MODE_TERMINAL;
          freq_entry_screen <= 1'b0;
        end
        // RULE5 combined values
        OMS_SEL_COMB_FREQ, OMS_SEL_COMB_RUN: begin
          mode              <= OMS_MODE_COMBINED;
          freq_entry_screen <= 1'b0;
        end
        default: begin
          mode              <= OMS_MODE_TERMINAL;
          freq_entry_screen <= 1'b0;
        end
      endcase
    // RULE8 keys act only in switching selection
    end else if (mode_sel_q == OMS_SEL_SWITCH) begin
      // RULE4 RULE2 panel key needs starts off
      if (panel_mode_key && starts_off && mode == OMS_MODE_TERMINAL) begin
        mode              <= OMS_MODE_PANEL;
        freq_entry_screen <= 1'b1;
      // RULE3 RULE4 terminal key needs idle run
      end else if (terminal_mode_key && starts_off && !run_active &&
                   mode == OMS_MODE_PANEL) begin
        mode              <= OMS_MODE_TERMINAL;
        freq_entry_screen <= 1'b0;
      end
      // RULE15 refused keys change nothing
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sources
  always_comb begin
    run_from_panel  = 1'b0;
    freq_from_panel = 1'b0;
    case (mode)
      OMS_MODE_PANEL: begin
        run_from_panel  = 1'b1;
        freq_from_panel = 1'b1;
      end
      OMS_MODE_COMBINED: begin
        // RULE6 RULE7 split sources
        run_from_panel  = (mode_sel_q == OMS_SEL_COMB_RUN);
        freq_from_panel = (mode_sel_q == OMS_SEL_COMB_FREQ);
      end
      default: begin
        run_from_panel  = 1'b0;
        freq_from_panel = 1'b0;
      end
    endcase
  end

  // Panel run latch; stop key or leaving panel run source ends it
  logic panel_run_q;
  logic panel_rev_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      panel_run_q <= 1'b0;
      panel_rev_q <= 1'b0;
    end else if (!run_from_panel || panel_stop_key) begin
      panel_run_q <= 1'b0;
    end else if (panel_fwd_key) begin
      panel_run_q <= 1'b1;
      panel_rev_q <= 1'b0;
    end else if (panel_rev_key) begin
      panel_run_q <= 1'b1;
      panel_rev_q <= 1'b1;
    end
  end

  // Both start inputs on counts as stop
  always_comb begin
    if (run_from_panel) begin
      run_active  = panel_run_q;
      run_reverse = panel_rev_q;
    end else begin
      run_active  = fwd_q ^ rev_q;
      run_reverse = rev_q && !fwd_q;
    end
  end

  assign terminal_mode_label = (mode == OMS_MODE_TERMINAL);
  assign combined_mode_label = (mode == OMS_MODE_COMBINED);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      accel_time_out <= RAMP_DFLT;
      decel_time_out <= RAMP_DFLT;
    end else begin
      accel_time_out <= accel_q;
      decel_time_out <= decel_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  logic [31:0] rd_d;

  always_comb begin
    rd_d = 32'h0000_0000;
    if (hit(reg_addr, OMS_REG_MODE_SEL)) begin
      rd_d[2:0] = mode_sel_q;
    end else if (hit(reg_addr, OMS_REG_ACCEL)) begin
      rd_d[15:0] = accel_q;
    end else if (hit(reg_addr, OMS_REG_DECEL)) begin
      rd_d[15:0] = decel_q;
    end else if (hit(reg_addr, OMS_REG_RAMP2)) begin
      rd_d[15:0] = ramp2_q;
    end else if (hit(reg_addr, OMS_REG_DECEL2)) begin
      rd_d[15:0] = decel2_q;
    end else if (hit(reg_addr, OMS_REG_EFF_DECEL)) begin
      rd_d[15:0] = eff_decel2;
    end else if (hit(reg_addr, OMS_REG_STATUS)) begin
      rd_d[OMS_ST_MODE_LSB +: 2]  = mode;
      rd_d[OMS_ST_RUN_SRC_BIT]    = run_from_panel;
      rd_d[OMS_ST_FRQ_SRC_BIT]    = freq_from_panel;
      rd_d[OMS_ST_FSCR_BIT]       = freq_entry_screen;
    end else begin
      for (int i = 0; i < OMS_CAL_NUM; i++) begin
        if (hit(reg_addr, OMS_REG_CAL_BASE + 8'(4 * i))) begin
          rd_d[15:0] = cal_q[i];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_d;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// file: bench/oms_panel_model.sv
// Model of the operator panel keys and the terminal start pins
`timescale 1ns/1ps
`default_nettype none
module oms_panel_model (
  // Clock
  input  wire logic       ref_clk,
  // Start pins and keys: mode, terminal, fwd, rev, stop
  output logic            fwd_pin,
  output logic            rev_pin,
  output logic [4:0]      keys
);
  initial begin
    fwd_pin = 1'b0;
    rev_pin = 1'b0;
    keys    = 5'h00;
  end
  // Pins are levels, like a switch to the input common
  task automatic pins(input logic f, input logic r);
    @(posedge ref_clk);
    fwd_pin <= f;
    rev_pin <= r;
  endtask
  // Keys are one-cycle pulses
  task automatic press(input int k);
    @(posedge ref_clk);
    keys <= 5'h01 << k;
    @(posedge ref_clk);
    keys <= 5'h00;
  endtask
endmodule
`default_nettype wire

// file: bench/oms_selector_sva.sv
// Port assertions for the operation mode selector
`timescale 1ns/1ps
`default_nettype none
module oms_selector_sva (
  // Clock, reset, register port
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  // Pins and keys
  input  wire logic               forward_start_input,
  input  wire logic               reverse_start_input,
  input  wire logic               panel_mode_key,
  input  wire logic               terminal_mode_key,
  // Mode outputs
  input  wire oms_pkg::oms_mode_t mode,
  input  wire logic               terminal_mode_label,
  input  wire logic               combined_mode_label,
  input  wire logic               freq_entry_screen,
  input  wire logic               run_from_panel,
  input  wire logic               freq_from_panel,
  input  wire logic               run_active
);
  import oms_pkg::*;
  logic [2:0] sel_q;
  logic       idle;
  assign idle = !forward_start_input && !reverse_start_input;
  // Shadow of the selection; values above 4 are refused
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sel_q <= 3'h0;
    end else if (reg_wr && reg_addr == OMS_REG_CLEAR && reg_wdata[1:0] != 2'h0) begin
      sel_q <= 3'h0;
    end else if (reg_wr && reg_addr == OMS_REG_MODE_SEL && reg_wdata[2:0] <= 3'h4) begin
      sel_q <= reg_wdata[2:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_reset_mode: assert property (
    $rose(nrst) |-> mode == OMS_MODE_TERMINAL && !freq_entry_screen)
    else $error("mode after reset is not terminal");
  a_label_decode: assert property (
    terminal_mode_label == (mode == OMS_MODE_TERMINAL)
    && combined_mode_label == (mode == OMS_MODE_COMBINED))
    else $error("mode label does not match mode");
  // Six idle cycles cover the start input filter
  a_panel_enter: assert property (
    (idle && sel_q == 3'h0 && mode == OMS_MODE_TERMINAL)[*6] ##0 (panel_mode_key && !reg_wr)
    |=> mode == OMS_MODE_PANEL && freq_entry_screen)
    else $error("panel key did not enter panel mode");
  a_term_return: assert property (
    (idle && sel_q == 3'h0 && mode == OMS_MODE_PANEL)[*6]
    ##0 (terminal_mode_key && !run_active && !reg_wr)
    |=> mode == OMS_MODE_TERMINAL && terminal_mode_label)
    else $error("terminal key did not return to terminal mode");
  a_start_block: assert property (
    (forward_start_input || reverse_start_input)[*6]
    ##0 ((panel_mode_key || terminal_mode_key) && !reg_wr)
    |=> $stable(mode) && $stable(freq_entry_screen))
    else $error("mode changed while a start input was on");
  a_comb_write: assert property (
    reg_wr && reg_addr == OMS_REG_MODE_SEL && reg_wdata inside {32'h3, 32'h4}
    |=> mode == OMS_MODE_COMBINED && combined_mode_label)
    else $error("combined selection did not enter combined mode");
  a_sel3_src: assert property (
    sel_q == 3'h3 |-> mode == OMS_MODE_COMBINED && freq_from_panel && !run_from_panel)
    else $error("selection 3 sources wrong");
  a_sel4_src: assert property (
    sel_q == 3'h4 |-> mode == OMS_MODE_COMBINED && run_from_panel && !freq_from_panel)
    else $error("selection 4 sources wrong");
  a_panel_only: assert property (
    sel_q == 3'h1 |-> mode == OMS_MODE_PANEL)
    else $error("selection 1 left panel mode");
  a_term_only: assert property (
    sel_q == 3'h2 |-> mode == OMS_MODE_TERMINAL)
    else $error("selection 2 left terminal mode");
endmodule
bind oms_selector oms_selector_sva u_sva (
  .ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
  .forward_start_input, .reverse_start_input, .panel_mode_key, .terminal_mode_key,
  .mode, .terminal_mode_label, .combined_mode_label, .freq_entry_screen,
  .run_from_panel, .freq_from_panel, .run_active
);
`default_nettype wire

// file: bench/test_oms_selector.sv
// Self-checking bench for the operation mode selector
`timescale 1ns/1ps
`default_nettype none
module test_oms_selector;
  import oms_pkg::*;
  logic        ref_clk   = 1'b0;
  logic        nrst      = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_rdata;
  logic        fwd, rev, term_lbl, comb_lbl, screen, run_pnl, frq_pnl, run_act;
  logic        run_rev;
  logic [4:0]  keys;
  logic [15:0] acc_o, dec_o;
  oms_mode_t   mode;
  int          bad_count = 0;
  int          compares  = 0;
  always #2 ref_clk = ~ref_clk;
  oms_panel_model panel (.ref_clk(ref_clk), .fwd_pin(fwd), .rev_pin(rev), .keys(keys));
  oms_selector #(.LARGE_RATING(1'b0)) dut (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .forward_start_input(fwd), .reverse_start_input(rev),
    .panel_mode_key(keys[0]), .terminal_mode_key(keys[1]), .panel_fwd_key(keys[2]),
    .panel_rev_key(keys[3]), .panel_stop_key(keys[4]), .mode(mode),
    .terminal_mode_label(term_lbl), .combined_mode_label(comb_lbl),
    .freq_entry_screen(screen), .run_from_panel(run_pnl), .freq_from_panel(frq_pnl),
    .run_active(run_act), .run_reverse(run_rev), .accel_time_out(acc_o), .decel_time_out(dec_o)
  );
  task automatic stop_test;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chm(input oms_mode_t e);
    chk({30'h0, mode}, {30'h0, e});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic kp(input int k);
    panel.press(k);
    #1;
  endtask
  task automatic start(input logic f, input logic r);
    panel.pins(f, r);
    tick(8);
  endtask
  // Strobe goes up after one edge and is taken at the next
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    tick(1);
    chm(OMS_MODE_TERMINAL);
    chk(term_lbl, 32'h1);
    chk(acc_o, OMS_TIME_SMALL);
    chk(dec_o, OMS_TIME_SMALL);
    rdc(OMS_REG_ACCEL, OMS_TIME_SMALL);
    rdc(OMS_REG_DECEL, OMS_TIME_SMALL);
    rdc(OMS_REG_RAMP2, OMS_TIME_RAMP2);
    rdc(8'h40, 32'h0);
    kp(0);
    chm(OMS_MODE_PANEL);
    chk(screen, 32'h1);
    start(1'b1, 1'b0);
    kp(1);
    chm(OMS_MODE_PANEL);
    start(1'b0, 1'b0);
    kp(2);
    kp(1);
    chm(OMS_MODE_PANEL);
    kp(4);
    kp(1);
    chm(OMS_MODE_TERMINAL);
    start(1'b0, 1'b1);
    chk({run_act, run_rev}, 32'h3);
    kp(0);
    chm(OMS_MODE_TERMINAL);
    start(1'b0, 1'b0);
    wr(OMS_REG_MODE_SEL, 32'h3);
    chk(comb_lbl, 32'h1);
    chk({run_pnl, frq_pnl}, 32'h1);
    rdc(OMS_REG_STATUS, 32'hA);
    start(1'b1, 1'b0);
    chk(run_act, 32'h1);
    start(1'b0, 1'b0);
    wr(OMS_REG_MODE_SEL, 32'h4);
    chk({run_pnl, frq_pnl}, 32'h2);
    kp(2);
    chk(run_act, 32'h1);
    kp(3);
    chk({run_act, run_rev}, 32'h3);
    kp(4);
    wr(OMS_REG_MODE_SEL, 32'h5);
    rdc(OMS_REG_MODE_SEL, 32'h4);
    wr(OMS_REG_MODE_SEL, 32'h1);
    kp(1);
    chm(OMS_MODE_PANEL);
    rdc(OMS_REG_STATUS, 32'h1D);
    wr(OMS_REG_MODE_SEL, 32'h2);
    kp(0);
    chm(OMS_MODE_TERMINAL);
    wr(OMS_REG_RAMP2, 32'h64);
    rdc(OMS_REG_EFF_DECEL, 32'h64);
    wr(OMS_REG_DECEL2, 32'h20);
    rdc(OMS_REG_EFF_DECEL, 32'h20);
    wr(OMS_REG_ACCEL, 32'h7);
    wr(OMS_REG_CAL_BASE, 32'h5A);
    wr(8'h28, 32'hA5);
    wr(OMS_REG_CLEAR, 32'h1);
    rdc(OMS_REG_ACCEL, OMS_TIME_SMALL);
    rdc(OMS_REG_DECEL2, OMS_SAME_AS_RAMP2);
    rdc(OMS_REG_CAL_BASE, 32'h5A);
    rdc(8'h28, 32'hA5);
    wr(OMS_REG_CLEAR, 32'h2);
    rdc(OMS_REG_CAL_BASE, OMS_CAL_RESET);
    rdc(8'h28, OMS_CAL_RESET);
    kp(0);
    chm(OMS_MODE_PANEL);
    stop_test;
  end
  // Whole run is well under two thousand cycles
  initial begin
    #20000;
    bad_count++;
    stop_test;
  end
endmodule
`default_nettype wire
